// ==== rtl/sqs_consts.svh ====
`ifndef SQS_CONSTS_SVH
`define SQS_CONSTS_SVH

// operation select codes: square and accumulate, root reuses it
`define SQS_OPSEL_CODE      7'b011_0101
`define SQS_ADDSUB_ADD      1'b0
`define SQS_ADDSUB_SUB      1'b1
`define SQS_IN_W_DEF        8
`define SQS_FRAC_W_DEF      4
`define SQS_MAX_SAMPLES_DEF 16

`endif

// ==== rtl/sqs_pkg.sv ====
`default_nettype none
package sqs_pkg;
	typedef enum logic [3:0] {
		SQS_IDLE  = 4'b0001,
		SQS_ACCUM = 4'b0010,
		SQS_ROOT  = 4'b0100,
		SQS_DONE  = 4'b1000
	} sqs_state_t;

	typedef enum logic {
		SQS_MODE_ROOT = 1'b0,
		SQS_MODE_SOS  = 1'b1
	} sqs_mode_t;
endpackage : sqs_pkg
`default_nettype wire

// ==== rtl/sqs_mac_slice.sv ====
`timescale 1ns/1ps
`default_nettype none
// square of one operand added to or subtracted from the other operand
module sqs_mac_slice #(
	parameter int SQ_W  = 8,
	parameter int ACC_W = 24
) (
	input  wire logic [SQ_W-1:0]  sq_operand_in,
	input  wire logic [ACC_W-1:0] acc_operand_in,
	input  wire logic             sub_sel_in,
	output logic      [ACC_W-1:0] result_out,
	output logic                  negative_out
);
	logic [2*SQ_W-1:0] product;
	logic [ACC_W:0]    wide;

	initial begin
		if (ACC_W < 2 * SQ_W) begin
			$error("accumulator narrower than the square");
		end
	end

	always_comb begin
		product = sq_operand_in * sq_operand_in;
		if (sub_sel_in) begin
			wide = {1'b0, acc_operand_in} - (ACC_W + 1)'(product);
		end else begin
			wide = {1'b0, acc_operand_in} + (ACC_W + 1)'(product);
		end
		result_out   = wide[ACC_W-1:0];
		negative_out = sub_sel_in & wide[ACC_W];
	end
endmodule : sqs_mac_slice
`default_nettype wire

// ==== rtl/sqs_root_core.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sqs_consts.svh"
// How it works
// - an N-bit operand gives a root whose integer part is ceil(N/2) bits
// - integer part takes ceil(N/2) clocks, then one fraction bit per clock
// - start loads operand into minuend (zero in sum-of-squares mode), trial root gets only its top bit
// - each iteration subtracts trial squared from operand, sign decides
// - non-negative difference keeps current trial bit, sets next lower bit
// - negative difference clears current trial bit, sets next lower bit
// - an 8-bit operand has its integer part after four iterations
// - 8-bit run for eight clocks: integer in upper, fraction in lower half
// - fraction iterations follow requested precision, one clock per bit
// - result is taken from the trial root, binary point between parts
// - sum-of-squares mode accumulates squares of two or n samples
// - accumulate n valid samples, align the sum in one more cycle, then run root iterations
// - add/subtract select adds while accumulating, subtracts for root
// - operation code 0110101, select zero to add and one to subtract
module sqs_root_core
	import sqs_pkg::*;
#(
	parameter int IN_W        = `SQS_IN_W_DEF,
	parameter int FRAC_W      = `SQS_FRAC_W_DEF,
	parameter int MAX_SAMPLES = `SQS_MAX_SAMPLES_DEF
) (
	input  wire logic                     mclk_in,
	input  wire logic                     nrst_in,
	input  wire logic                     start_in,
	input  wire sqs_pkg::sqs_mode_t       mode_in,
	input  wire logic [IN_W-1:0]          operand_in,
	input  wire logic [$clog2(FRAC_W+1)-1:0] frac_bits_in,
	input  wire logic [$clog2(MAX_SAMPLES+1)-1:0] samples_in,
	input  wire logic                     sample_valid_in,
	input  wire logic [IN_W-1:0]          sample_in,
	output logic      [(IN_W+1)/2+FRAC_W-1:0] root_out,
	output logic      [6:0]               operation_select_code_out,
	output logic                          sub_sel_out,
	output logic                          busy_out,
	output logic                          done_out
);
	import sqs_pkg::*;

	localparam int INT_W  = (IN_W + 1) / 2;
	localparam int ROOT_W = INT_W + FRAC_W;
	localparam int MIN_W  = 2 * ROOT_W;
	localparam int ACC_W  = 2 * IN_W + $clog2(MAX_SAMPLES + 1);
	localparam int WORK_W = (ACC_W > MIN_W) ? ACC_W : MIN_W;
	localparam int CNT_W  = $clog2(ROOT_W + MAX_SAMPLES + 1);

	initial begin
		if (IN_W < 2 || FRAC_W < 0 || MAX_SAMPLES < 1) begin
			$error("unsupported root core parameters");
		end
	end

	sqs_state_t          state_r;
	logic [WORK_W-1:0]   minuend_r;
	logic [ROOT_W-1:0]   trial_r;
	logic [CNT_W-1:0]    cnt_r;
	logic [CNT_W-1:0]    last_r;
	logic [CNT_W-1:0]    samples_left_r;
	logic [WORK_W-1:0]   slice_res;
	logic                slice_neg;
	logic [ROOT_W-1:0]   trial_nxt;
	logic [ROOT_W-1:0]   sq_operand;
	logic                sub_sel;

	function automatic logic [WORK_W-1:0] align_operand(
		input logic [WORK_W-1:0] value
	);
		// integer value moved above 2*FRAC_W zero bits, like trial squared
		return value << (2 * FRAC_W);
	endfunction : align_operand

	assign sub_sel    = (state_r == SQS_ROOT);
	assign sq_operand = (state_r == SQS_ACCUM) ?
		ROOT_W'(sample_in) : trial_r;

	sqs_mac_slice #(
		.SQ_W (ROOT_W),
		.ACC_W(WORK_W)
	) u_slice (
		.sq_operand_in (sq_operand),
		.acc_operand_in(minuend_r),
		.sub_sel_in    (sub_sel),
		.result_out    (slice_res),
		.negative_out  (slice_neg)
	);

	// decision: keep or clear current bit, then set next lower bit
	always_comb begin
		trial_nxt = trial_r;
		for (int i = ROOT_W - 1; i >= 0; i--) begin
			if (CNT_W'(ROOT_W - 1 - i) == cnt_r) begin
				trial_nxt[i] = ~slice_neg;
				if (i > 0) begin
					trial_nxt[i-1] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_r        <= SQS_IDLE;
			cnt_r          <= '0;
			last_r         <= '0;
			samples_left_r <= '0;
		end else begin
			case (state_r)
			SQS_IDLE, SQS_DONE: begin
				state_r <= SQS_IDLE;
				if (start_in) begin
					cnt_r  <= '0;
					// index of the last iteration: integer bits plus requested fraction bits, minus one
					last_r <= CNT_W'(INT_W) + CNT_W'(frac_bits_in)
						- CNT_W'(1);
					if (mode_in == SQS_MODE_SOS) begin
						samples_left_r <= CNT_W'(samples_in);
						state_r        <= SQS_ACCUM;
					end else begin
						state_r <= SQS_ROOT;
					end
				end
			end
			SQS_ACCUM: begin
				if (samples_left_r == '0) begin
					state_r <= SQS_ROOT;
				end else if (sample_valid_in) begin
					samples_left_r <= samples_left_r - CNT_W'(1);
				end
			end
			SQS_ROOT: begin
				cnt_r <= cnt_r + CNT_W'(1);
				if (cnt_r == last_r) begin
					state_r <= SQS_DONE;
				end
			end
			default: state_r <= SQS_IDLE;
			endcase
		end
	end

	// minuend loaded at start, grown by squares while accumulating
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			minuend_r <= '0;
		end else if ((state_r == SQS_IDLE || state_r == SQS_DONE)
			&& start_in) begin
			if (mode_in == SQS_MODE_SOS) begin
				minuend_r <= '0;
			end else begin
				minuend_r <= align_operand(WORK_W'(operand_in));
			end
		end else if (state_r == SQS_ACCUM && samples_left_r == '0) begin
			minuend_r <= align_operand(minuend_r);
		end else if (state_r == SQS_ACCUM && sample_valid_in
			&& samples_left_r != '0) begin
			minuend_r <= slice_res;
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			trial_r <= '0;
		end else if ((state_r == SQS_IDLE || state_r == SQS_DONE)
			&& start_in) begin
			trial_r <= {1'b1, {(ROOT_W-1){1'b0}}};
		end else if (state_r == SQS_ACCUM) begin
			trial_r <= {1'b1, {(ROOT_W-1){1'b0}}};
		end else if (state_r == SQS_ROOT) begin
			trial_r <= trial_nxt;
		end
	end

	// fraction bits not asked for stay zero in the result
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			root_out <= '0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (state_r == SQS_ROOT && cnt_r == last_r) begin
				root_out <= trial_nxt & ~(ROOT_W'({ROOT_W{1'b1}})
					>> (cnt_r + CNT_W'(1)));
				done_out <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			operation_select_code_out <= 7'h00;
			sub_sel_out               <= `SQS_ADDSUB_ADD;
			busy_out                  <= 1'b0;
		end else begin
			operation_select_code_out <= `SQS_OPSEL_CODE;
			sub_sel_out <= (state_r == SQS_ROOT || (state_r == SQS_ACCUM
				&& samples_left_r == '0)) ?
				`SQS_ADDSUB_SUB : `SQS_ADDSUB_ADD;
			busy_out <= (state_r == SQS_ACCUM) || (state_r == SQS_ROOT
				&& cnt_r != last_r) || (((state_r == SQS_IDLE)
				|| (state_r == SQS_DONE)) && start_in);
		end
	end

	property p_done_pulse;
		@(posedge mclk_in) disable iff (!nrst_in)
		done_out |=> !done_out;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("done longer than one cycle");

	property p_root_hold;
		@(posedge mclk_in) disable iff (!nrst_in)
		(!done_out && state_r != SQS_ROOT) |=> $stable(root_out);
	endproperty
	a_root_hold: assert property (p_root_hold)
		else $error("root changed without completion");

	property p_code_fixed;
		@(posedge mclk_in) disable iff (!nrst_in)
		$past(nrst_in) |-> operation_select_code_out == `SQS_OPSEL_CODE;
	endproperty
	a_code_fixed: assert property (p_code_fixed)
		else $error("operation code wrong");

	sequence s_root_start;
		(state_r == SQS_IDLE || state_r == SQS_DONE) && start_in
		&& mode_in == SQS_MODE_ROOT && frac_bits_in == '0;
	endsequence
	property p_int_latency;
		@(posedge mclk_in) disable iff (!nrst_in)
		s_root_start |-> ##(INT_W + 1) done_out;
	endproperty
	a_int_latency: assert property (p_int_latency)
		else $error("integer part not done after N/2 clocks");

	property p_trial_init;
		@(posedge mclk_in) disable iff (!nrst_in)
		(state_r == SQS_IDLE || state_r == SQS_DONE) && start_in
		|=> trial_r == {1'b1, {(ROOT_W-1){1'b0}}};
	endproperty
	a_trial_init: assert property (p_trial_init)
		else $error("trial root not initialised");

	property p_clear_on_neg;
		@(posedge mclk_in) disable iff (!nrst_in)
		(state_r == SQS_ROOT && slice_neg && cnt_r < CNT_W'(ROOT_W))
		|=> trial_r[ROOT_W - 1 - $past(cnt_r)] == 1'b0;
	endproperty
	a_clear_on_neg: assert property (p_clear_on_neg)
		else $error("trial bit not cleared");

	property p_keep_on_pos;
		@(posedge mclk_in) disable iff (!nrst_in)
		(state_r == SQS_ROOT && !slice_neg && cnt_r < CNT_W'(ROOT_W))
		|=> trial_r[ROOT_W - 1 - $past(cnt_r)] == 1'b1;
	endproperty
	a_keep_on_pos: assert property (p_keep_on_pos)
		else $error("trial bit not kept");

	property p_sub_in_root;
		@(posedge mclk_in) disable iff (!nrst_in)
		(state_r == SQS_ROOT) |-> sub_sel ##1 sub_sel_out;
	endproperty
	a_sub_in_root: assert property (p_sub_in_root)
		else $error("root cycles not subtracting");

	property p_accum_adds;
		@(posedge mclk_in) disable iff (!nrst_in)
		(state_r == SQS_ACCUM && samples_left_r != '0) |=> !sub_sel_out;
	endproperty
	a_accum_adds: assert property (p_accum_adds)
		else $error("accumulate cycles not adding");
endmodule : sqs_root_core
`default_nettype wire

// ==== dv/sqs_fabric.sv ====
`timescale 1ns/1ps
`default_nettype none
// fabric side: presents operands and samples, collects the root
module sqs_fabric (
	input  wire logic         mclk_in,
	input  wire logic         done_in,
	input  wire logic         busy_in,
	input  wire logic         sub_sel_in,
	input  wire logic [7:0]   root_in,
	output var sqs_pkg::sqs_mode_t mode_out,
	output logic              start_out,
	output logic      [7:0]   operand_out,
	output logic      [2:0]   frac_out,
	output logic      [4:0]   samples_out,
	output logic              valid_out,
	output logic      [7:0]   sample_out
);
	import sqs_pkg::*;
	logic [7:0] smp [16];
	initial begin
		mode_out = SQS_MODE_ROOT;
		start_out = 1'b0;
		operand_out = 8'h00;
		frac_out = 3'h0;
		samples_out = 5'h00;
		valid_out = 1'b0;
		sample_out = 8'h00;
	end
	// poke raises start once more at that edge; a start still up is reused
	task automatic job(input sqs_mode_t m, input logic [7:0] op,
		input logic [2:0] fb, input logic [4:0] ns, input int poke,
		output int n, output logic [7:0] r, output logic s, output logic b,
		output logic bm);
		if (start_out !== 1'b1) begin
			@(posedge mclk_in);
			mode_out <= m;
			operand_out <= op;
			frac_out <= fb;
			samples_out <= ns;
			start_out <= 1'b1;
			@(posedge mclk_in);
		end
		start_out <= 1'b0;
		if (m == SQS_MODE_SOS) begin
			valid_out <= 1'b1;
			sample_out <= smp[0];
		end
		n = 0;
		do begin
			@(posedge mclk_in);
			n++;
			if (n == 2) begin
				s = sub_sel_in;
				bm = busy_in;
			end
			if (m == SQS_MODE_SOS && n < ns) sample_out <= smp[n];
			else begin
				valid_out <= 1'b0;
				sample_out <= ~sample_out;
			end
			if (n + 1 == poke) start_out <= 1'b1;
			else if (n == poke && done_in !== 1'b1) start_out <= 1'b0;
		end while (done_in !== 1'b1 && n < 100);
		r = root_in;
		b = busy_in;
	endtask : job
endmodule : sqs_fabric
`default_nettype wire

// ==== dv/iterative_sqrt_sum_squares_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module iterative_sqrt_sum_squares_tb;
	import sqs_pkg::*;
	logic       mclk = 1'b0;
	logic       nrst = 1'b0;
	logic       start, valid, sub_sel, busy, done;
	sqs_mode_t  mode;
	logic [7:0] operand, sample, root;
	logic [2:0] frac;
	logic [4:0] nsamp;
	logic [6:0] opsel;
	int         num_errors = 0;
	int         tests_run = 0;
	always #50 mclk = ~mclk;
	sqs_root_core uut (.mclk_in(mclk), .nrst_in(nrst), .start_in(start),
		.mode_in(mode), .operand_in(operand), .frac_bits_in(frac),
		.samples_in(nsamp), .sample_valid_in(valid), .sample_in(sample),
		.root_out(root), .operation_select_code_out(opsel),
		.sub_sel_out(sub_sel), .busy_out(busy), .done_out(done));
	sqs_fabric fab (.mclk_in(mclk), .done_in(done), .busy_in(busy),
		.sub_sel_in(sub_sel), .root_in(root), .mode_out(mode),
		.start_out(start), .operand_out(operand), .frac_out(frac),
		.samples_out(nsamp), .valid_out(valid), .sample_out(sample));
	task automatic chk_val(string what, logic [7:0] exp, logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_val
	task automatic chk_cnt(string what, int exp, int got);
		tests_run++;
		if (got != exp) begin
			num_errors++;
			$display("Error %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chk_cnt
	function automatic logic [7:0] ref_root(input logic [15:0] v, int fb);
		logic [7:0] r;
		logic [7:0] t;
		r = 8'h00;
		for (int b = 7; b >= 0; b--) begin
			t = r | (8'h01 << b);
			if (t * t <= v) r = t;
		end
		return r & (8'hff << (4 - fb));
	endfunction : ref_root
	task automatic run(sqs_mode_t m, logic [7:0] op, int fb, int ns,
		int poke, logic [7:0] sum);
		int n;
		int lat;
		logic [7:0] r;
		logic s, b, bm;
		lat = 4 + fb + 1 + ((m == SQS_MODE_SOS) ? ns + 1 : 0);
		fab.job(m, op, fb[2:0], ns[4:0], poke, n, r, s, b, bm);
		chk_val("root", ref_root({sum, 8'h00}, fb), r);
		chk_cnt("edges to done", lat, n);
		chk_val("busy mid", 8'h01, {7'h00, bm});
		chk_val("sub sel", {7'h00, m == SQS_MODE_ROOT}, {7'h00, s});
		chk_val("busy at done", 8'h00, {7'h00, b});
		chk_val("op code", 8'h35, {1'b0, opsel});
	endtask : run
	task automatic t_reset;
		repeat (4) @(posedge mclk);
		chk_val("reset root", 8'h00, root);
		chk_val("reset done", 8'h00, {busy, done, 6'h00});
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		repeat (2) @(posedge mclk);
		chk_val("op code", 8'h35, {1'b0, opsel});
		$display("test reset done");
	endtask : t_reset
	task automatic t_root;
		logic [7:0] ops [5] = '{8'h00, 8'h01, 8'h90, 8'hc8, 8'hff};
		for (int f = 0; f <= 4; f++) run(SQS_MODE_ROOT, 8'h0b, f, 0, 0, 8'h0b);
		foreach (ops[i]) run(SQS_MODE_ROOT, ops[i], 4, 0, 0, ops[i]);
		$display("test root done");
	endtask : t_root
	task automatic t_sos;
		fab.smp[0] = 8'h01;
		fab.smp[1] = 8'h02;
		fab.smp[2] = 8'h03;
		run(SQS_MODE_SOS, 8'hff, 4, 3, 0, 8'h0e);
		fab.smp[0] = 8'h03;
		fab.smp[1] = 8'h04;
		run(SQS_MODE_SOS, 8'h00, 0, 2, 0, 8'h19);
		$display("test sos done");
	endtask : t_sos
	task automatic t_refuse_hold;
		logic [7:0] r0;
		run(SQS_MODE_ROOT, 8'h0b, 4, 0, 2, 8'h0b);
		r0 = root;
		repeat (3) @(posedge mclk);
		chk_val("held root", r0, root);
		chk_val("idle busy", 8'h00, {7'h00, busy});
		$display("test refuse done");
	endtask : t_refuse_hold
	task automatic t_b2b;
		run(SQS_MODE_ROOT, 8'hc8, 4, 0, 9, 8'hc8);
		run(SQS_MODE_ROOT, 8'hc8, 4, 0, 0, 8'hc8);
		$display("test back to back done");
	endtask : t_b2b
	task automatic conclude;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	initial begin
		#500000;
		num_errors++;
		conclude();
	end
	initial begin
		t_reset();
		t_root();
		t_sos();
		t_refuse_hold();
		t_b2b();
		conclude();
	end
endmodule : iterative_sqrt_sum_squares_tb
`default_nettype wire
